// >>> src/gtt_timers.sv
// two global-time timers with wishbone register access and a shared interrupt
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module gtt_timers #(
   parameter int NUM_TIMERS = 2
) (
   input wire logic sys_clk, // 40 MHz system clock
   input wire logic rst, // asynchronous reset, active high
   input wire logic [gtt_pkg::ADDR_W-1:0] wbAdr, // byte address
   input wire logic [31:0] wbDatI, // write data
   input wire logic [3:0] wbSel, // byte lane selects
   input wire logic wbWe, // write enable
   input wire logic wbCyc, // bus cycle
   input wire logic wbStb, // strobe
   input wire logic [5:0] cycleCount, // controller cycle counter
   input wire logic [15:0] macrotick, // macrotick count since cycle start
   output logic [31:0] wbDatO, // read data, registered
   output logic wbAck, // acknowledge, registered
   output logic [1:0] timerEvent, // one-cycle pulse per timer, registered
   output logic irq // level interrupt, registered
);
   // usage notes for software and integrators:
   // - a register sits at a byte address four times its index
   // - only the low half of the data bus carries register contents
   // - writes honour byte lanes 0 and 1; lanes 2 and 3 reach no register
   // - cycle-set reserved bits are dropped on write and read back as zero
   // - membership compares only the low exponent bits of cycle and base,
   //   so a base at or above two to the exponent aliases onto a smaller one
   // - an exponent of seven is outside the supported range; it compares all six cycle bits
   // - each timer fires at most once per cycle number
   // - a timer re-arms when the cycle number changes
   // - a macrotick that stalls on the offset does not flood the interrupt line
   // - moving the offset within a cycle after the timer fired does not fire it again there
   // - reset leaves both timers matching every cycle at macrotick zero,
   //   so software programs them before the cycle counter starts
   // - the status register clears on read and returns the value before the clear
   // - an event in the clearing cycle survives the clear
   // - the mask register has the layout of the status register
   // - the interrupt line follows status and mask from a flip-flop
   // - every access is answered one cycle after it is taken, reads included
   // - the master may present the next request in the cycle after the acknowledge
   // - a strobe left high through the acknowledge cycle is not taken twice
   // - read data is valid only in the acknowledge cycle
   // - unmapped indices read zero and ignore writes, but are still acknowledged
   // - cycle and macrotick inputs are taken as synchronous to the system clock
   // - the macrotick input is expected to restart from zero in each new cycle
   // - a cycle number that jumps still re-arms, since only a change is looked at
   // - the timer pulse and the status bit rise on the same edge
   // - with no buffering, an event is lost only if status was already set

   // bits of a cycle-set register that are stored; the rest are reserved
   localparam logic [15:0] CSET_KEEP = (16'h003f << gtt_pkg::BASE_LSB) | (16'h0007 << gtt_pkg::REP_LSB);

   typedef struct packed {
      gtt_pkg::gtt_bus_t bus;
      logic [31:0] rdat;
      logic [1:0][15:0] cset;
      logic [1:0][15:0] offs;
      logic [1:0] done;
      logic [1:0] evt;
      logic [1:0] stat;
      logic [1:0] mask;
      logic irq;
      logic [5:0] lastCycle;
   } gtt_state_t;

   gtt_state_t st_r, st_nxt;

   // elaboration check: the register map holds exactly two timers
   if (NUM_TIMERS != 2) begin : g_chk
      $error("gtt_timers supports exactly two timers");
   end

   // elaboration checks: the package layout must agree with what the logic assumes
   if (gtt_pkg::BASE_W != 6) begin : g_chk_base
      $error("base cycle field must match the six-bit cycle counter");
   end
   if (gtt_pkg::REP_W != 3) begin : g_chk_rep
      $error("repetition exponent field must be three bits");
   end
   if (gtt_pkg::BASE_LSB + gtt_pkg::BASE_W > gtt_pkg::REP_LSB) begin : g_chk_overlap
      $error("base cycle and exponent fields overlap");
   end
   if (gtt_pkg::REP_LSB + gtt_pkg::REP_W > 16) begin : g_chk_top
      $error("exponent field leaves the 16-bit register");
   end
   if (int'(gtt_pkg::REP_MAX) > gtt_pkg::BASE_W) begin : g_chk_repmax
      $error("largest exponent exceeds the cycle counter width");
   end
   if (gtt_pkg::ADDR_W < 10) begin : g_chk_adr
      $error("address too narrow for the register index");
   end
   if (gtt_pkg::IDX_T1_CYCLE_SET != gtt_pkg::IDX_T0_CYCLE_SET + 8'h04) begin : g_chk_cs_pair
      $error("timer cycle-set registers must lie four indices apart");
   end
   if (gtt_pkg::IDX_T1_OFFSET != gtt_pkg::IDX_T0_OFFSET + 8'h04) begin : g_chk_of_pair
      $error("timer offset registers must lie four indices apart");
   end
   if (gtt_pkg::CFG_RESET != 16'h0000) begin : g_chk_reset
      $error("timer configuration must clear to zero");
   end
   if (gtt_pkg::IDX_IRQ_STATUS == gtt_pkg::IDX_IRQ_MASK) begin : g_chk_irq_idx
      $error("status and mask need their own indices");
   end
   if (gtt_pkg::IDX_IRQ_STATUS >= gtt_pkg::IDX_T0_CYCLE_SET
       && gtt_pkg::IDX_IRQ_STATUS <= gtt_pkg::IDX_T1_OFFSET) begin : g_chk_stat_idx
      $error("status index collides with the timer registers");
   end
   if ((gtt_pkg::BUS_IDLE & gtt_pkg::BUS_ACK) != 2'b00) begin : g_chk_onehot
      $error("bus states must be one-hot");
   end

   // cycle membership: low c bits of cycle equal base (base < 2^c assumed)
   function automatic logic cycleHit(input logic [15:0] cs, input logic [5:0] cyc);
      logic [5:0] msk;
      logic [2:0] rep;
      rep = cs[gtt_pkg::REP_LSB +: gtt_pkg::REP_W];
      msk = 6'((7'h01 << rep) - 7'h01);
      cycleHit = ((cyc & msk) == (cs[gtt_pkg::BASE_LSB +: gtt_pkg::BASE_W] & msk));
   endfunction

   // byte-lane mask of a 16-bit register; the upper lanes reach no register
   function automatic logic [15:0] laneMask(input logic [3:0] sel);
      laneMask = {sel[1] ? 8'hff : 8'h00, sel[0] ? 8'hff : 8'h00};
   endfunction

   // merge a write: only selected lanes change, only kept bits are stored
   function automatic logic [15:0] mergeWrite(input logic [15:0] old, input logic [3:0] sel,
         input logic [15:0] dat, input logic [15:0] keep);
      logic [15:0] lanes;
      lanes = laneMask(sel) & keep;
      mergeWrite = (old & ~lanes) | (dat & lanes);
   endfunction

   // index of timer i's cycle-set register
   function automatic logic [7:0] csetIdx(input int i);
      csetIdx = gtt_pkg::IDX_T0_CYCLE_SET + 8'(4 * i);
   endfunction

   // index of timer i's offset register
   function automatic logic [7:0] offsIdx(input int i);
      offsIdx = gtt_pkg::IDX_T0_OFFSET + 8'(4 * i);
   endfunction

   // cycle-set read view with reserved bits forced to zero
   function automatic logic [31:0] csetView(input logic [15:0] cs);
      csetView = {16'h0000, cs & CSET_KEEP};
   endfunction

   // due: cycle in the set, offset reached, not yet fired in this cycle
   function automatic logic timerDue(input logic [15:0] cs, input logic [15:0] ofs, input logic [5:0] cyc,
         input logic [15:0] mt, input logic fired, input logic [5:0] prevCyc);
      logic inSet;
      logic atOffset;
      logic spent;
      inSet = cycleHit(cs, cyc);
      atOffset = (mt == ofs);
      spent = fired && (cyc == prevCyc);
      timerDue = inSet && atOffset && !spent;
   endfunction

   // bus state machine: idle takes a request, the ack state lasts exactly one cycle
   function automatic gtt_pkg::gtt_bus_t busNext(input gtt_pkg::gtt_bus_t cur, input logic req);
      case (cur)
         gtt_pkg::BUS_IDLE: begin
            if (req) begin
               busNext = gtt_pkg::BUS_ACK;
            end else begin
               busNext = gtt_pkg::BUS_IDLE;
            end
         end
         gtt_pkg::BUS_ACK: begin
            busNext = gtt_pkg::BUS_IDLE;
         end
         default: begin
            busNext = gtt_pkg::BUS_IDLE;
         end
      endcase
   endfunction

   // apply one register write; unmapped indices leave the state unchanged
   function automatic gtt_state_t writeRegs(input gtt_state_t s, input logic [7:0] idx, input logic [3:0] sel,
         input logic [31:0] dat);
      writeRegs = s;
      for (int i = 0; i < 2; i++) begin
         if (idx == csetIdx(i)) begin
            writeRegs.cset[i] = mergeWrite(s.cset[i], sel, dat[15:0], CSET_KEEP);
         end
         if (idx == offsIdx(i)) begin
            writeRegs.offs[i] = mergeWrite(s.offs[i], sel, dat[15:0], 16'hffff);
         end
      end
      if (idx == gtt_pkg::IDX_IRQ_MASK && sel[0]) begin
         writeRegs.mask = dat[1:0];
      end
   endfunction

   // sticky status: a set in the clearing cycle wins over the clear
   function automatic logic [1:0] statusNext(input logic [1:0] stat, input logic [1:0] clr, input logic [1:0] evt);
      statusNext = (stat & ~clr) | evt;
   endfunction

   // level interrupt: any unmasked status bit
   function automatic logic irqLevel(input logic [1:0] stat, input logic [1:0] mask);
      irqLevel = |(stat & mask);
   endfunction

   // read mux by register index
   function automatic logic [31:0] readReg(input gtt_state_t s, input logic [7:0] idx);
      if (idx == gtt_pkg::IDX_T0_CYCLE_SET) begin
         readReg = csetView(s.cset[0]);
      end else if (idx == gtt_pkg::IDX_T0_OFFSET) begin
         readReg = {16'h0000, s.offs[0]};
      end else if (idx == gtt_pkg::IDX_T1_CYCLE_SET) begin
         readReg = csetView(s.cset[1]);
      end else if (idx == gtt_pkg::IDX_T1_OFFSET) begin
         readReg = {16'h0000, s.offs[1]};
      end else if (idx == gtt_pkg::IDX_IRQ_STATUS) begin
         readReg = {30'h00000000, s.stat};
      end else if (idx == gtt_pkg::IDX_IRQ_MASK) begin
         readReg = {30'h00000000, s.mask};
      end else begin
         readReg = 32'h00000000; // unmapped reads zero, still acknowledged
      end
   endfunction

   // next-state logic
   always_comb begin
      logic [7:0] idx;
      logic wr;
      logic rd;
      logic [1:0] clr;
      st_nxt = st_r;
      idx = 8'(wbAdr[gtt_pkg::ADDR_W-1:2]);
      wr = 1'b0;
      rd = 1'b0;
      clr = 2'h0;
      st_nxt.evt = 2'h0;
      st_nxt.lastCycle = cycleCount;
      // classic wishbone: one wait state, ack dropped after one cycle
      st_nxt.bus = busNext(st_r.bus, wbCyc && wbStb);
      // taken only from idle, so a strobe left high in the ack cycle is not taken twice
      if (st_r.bus == gtt_pkg::BUS_IDLE && wbCyc && wbStb) begin
         wr = wbWe;
         rd = !wbWe;
         st_nxt.rdat = readReg(st_r, idx);
      end
      // register writes honour low byte lanes; reserved bits are not stored
      if (wr) begin
         st_nxt = writeRegs(st_nxt, idx, wbSel, wbDatI);
      end
      if (rd && idx == gtt_pkg::IDX_IRQ_STATUS) begin
         clr = 2'h3; // read clears status
      end
      // timers: compare offset in matching cycles, once per cycle
      for (int i = 0; i < 2; i++) begin
         if (cycleCount != st_r.lastCycle) begin
            st_nxt.done[i] = 1'b0; // new cycle re-arms
         end
         if (timerDue(st_r.cset[i], st_r.offs[i], cycleCount, macrotick, st_r.done[i], st_r.lastCycle)) begin
            st_nxt.evt[i] = 1'b1;
            st_nxt.done[i] = 1'b1;
         end
      end
      // sticky status: a set in the clearing cycle wins
      st_nxt.stat = statusNext(st_r.stat, clr, st_nxt.evt);
      st_nxt.irq = irqLevel(st_nxt.stat, st_nxt.mask);
   end

   // state register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r.bus <= gtt_pkg::BUS_IDLE;
         st_r.rdat <= 32'h00000000;
         st_r.cset <= {gtt_pkg::CFG_RESET, gtt_pkg::CFG_RESET};
         st_r.offs <= {gtt_pkg::CFG_RESET, gtt_pkg::CFG_RESET};
         st_r.done <= 2'h0;
         st_r.evt <= 2'h0;
         st_r.stat <= 2'h0;
         st_r.mask <= gtt_pkg::MASK_RESET;
         st_r.irq <= 1'b0;
         st_r.lastCycle <= 6'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wbDatO = st_r.rdat;
   assign wbAck = (st_r.bus == gtt_pkg::BUS_ACK);
   assign timerEvent = st_r.evt;
   assign irq = st_r.irq;
endmodule

// >>> src/gtt_pkg.sv
// constants, register map and state type for the global-time timer interrupt block
// Summary of operation
// - two independent timers, each with a cycle-set and an offset register
// - cycle set is nine bits: six-bit base cycle, three-bit repetition exponent
// - in a matching cycle, fire when macrotick count reaches the 16-bit offset
// - hard reset clears all four timer configuration registers to zero
// - base cycle in bits 5..0, exponent in bits 10..8, other bits read zero
// - timer 1 offset register holds a full 16-bit read/write offset
package gtt_pkg;
   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_T0_CYCLE_SET = 8'h30;
   localparam logic [7:0] IDX_T0_OFFSET = 8'h32;
   localparam logic [7:0] IDX_T1_CYCLE_SET = 8'h34;
   localparam logic [7:0] IDX_T1_OFFSET = 8'h36;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h38;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h39;
   localparam int BASE_LSB = 0;
   localparam int BASE_W = 6;
   localparam int REP_LSB = 8;
   localparam int REP_W = 3;
   localparam logic [2:0] REP_MAX = 3'h6;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam int ADDR_W = 10;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } gtt_bus_t;
endpackage

// >>> dv/gtt_timers_asserts.sv
// checker for the global-time timer block, bound to its top ports
`timescale 1ns/1ps
module gtt_timers_chk (
   input wire logic sys_clk, // clock
   input wire logic rst, // reset
   input wire logic [9:0] wbAdr, // address
   input wire logic [31:0] wbDatI, // write data
   input wire logic [3:0] wbSel, // lanes
   input wire logic wbWe, // write
   input wire logic wbCyc, // cycle
   input wire logic wbStb, // strobe
   input wire logic [5:0] cycleCount, // cycle number
   input wire logic [15:0] macrotick, // macrotick
   input wire logic [31:0] wbDatO, // read data
   input wire logic wbAck, // ack
   input wire logic [1:0] timerEvent, // events
   input wire logic irq // interrupt
);
   logic [1:0] maskM;
   // mirror lags the real mask by a cycle, so no event is timed next to a mask write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) maskM <= 2'h0;
      else if (wbAck && wbWe && wbAdr[9:2] == 8'h39) maskM <= wbDatI[1:0];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_ACK_LAT: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("ack late");
   AST_ACK_PULSE: assert property (wbAck |=> !wbAck) else $error("ack long");
   AST_EVT_PULSE: assert property (timerEvent != 2'h0 |=> (timerEvent & $past(timerEvent)) == 2'h0) else $error("ev long");
   AST_EVT_ONCE: assert property (timerEvent[1] ##1 $stable(cycleCount)[*2] |-> !timerEvent[1]) else $error("ev again");
   AST_RSV: assert property (wbAck && !wbWe && wbAdr[9:2] inside {8'h30, 8'h34} |-> (wbDatO & 32'hf8c0) == 32'h0) else $error("rsv");
   AST_UNMAP: assert property (wbAck && !wbWe && !(wbAdr[9:2] inside {[8'h30:8'h39]}) |-> wbDatO == 32'h0) else $error("unmap");
   AST_UPPER: assert property (wbAck |-> wbDatO[31:16] == 16'h0) else $error("upper");
   AST_IRQ: assert property ((timerEvent & maskM) != 2'h0 |-> irq) else $error("irq");
   COV_EV0: cover property (timerEvent[0]);
   COV_EV1: cover property (timerEvent[1] ##1 $stable(cycleCount)[*2]);
   COV_IRQ: cover property ($fell(irq));
endmodule

// >>> dv/tb.sv
// register and timer tests for the global-time timer block
`timescale 1ns/1ps
module tb;
   logic sys_clk, rst, wbWe, wbCyc, wbStb, wbAck, irq;
   logic [9:0] wbAdr;
   logic [31:0] wbDatI, wbDatO, rd;
   logic [3:0] wbSel;
   logic [5:0] cycleCount;
   logic [15:0] macrotick;
   logic [1:0] timerEvent;
   int miscompares = 0, checks = 0, ev0 = 0, ev1 = 0;
   gtt_timers dut (.sys_clk(sys_clk), .rst(rst), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbSel(wbSel), .wbWe(wbWe),
      .wbCyc(wbCyc), .wbStb(wbStb), .cycleCount(cycleCount), .macrotick(macrotick), .wbDatO(wbDatO),
      .wbAck(wbAck), .timerEvent(timerEvent), .irq(irq));
   initial begin
      sys_clk = 0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // events counted on the falling edge, where the pulse is settled
   always @(negedge sys_clk) begin
      ev0 += int'(timerEvent[0] === 1'b1);
      ev1 += int'(timerEvent[1] === 1'b1);
   end
   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   // one classic cycle: request held until the rising edge that samples ack high, data taken there
   task automatic bus(input logic [7:0] i, input logic w, input logic [15:0] d);
      int n;
      @(posedge sys_clk);
      {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, w, i, 2'b00, 16'h0, d};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      rd = wbDatO;
      if (n >= 20) begin
         miscompares++;
         finish_test();
      end
      {wbCyc, wbStb} <= 2'b00;
   endtask
   initial begin
      // macrotick parked off zero so the reset configuration cannot fire before programming
      {rst, wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel, cycleCount, macrotick} = {4'h8, 10'h0, 32'h0, 4'hf, 6'h0,
         16'hffff};
      repeat (16) @(posedge sys_clk);
      rst <= 0;
      for (int i = 0; i < 4; i++) begin
         bus(8'h30 + 8'(2 * i), 0, 16'h0);
         chk("cfg", rd, 32'h0);
      end
      bus(8'h30, 1, 16'hffff);
      bus(8'h30, 0, 16'h0);
      chk("cset", rd, 32'h073f);
      bus(8'h36, 1, 16'ha5c3);
      bus(8'h36, 0, 16'h0);
      chk("ofs1", rd, 32'ha5c3);
      bus(8'h3a, 0, 16'h0);
      chk("unmap", rd, 32'h0);
      bus(8'h30, 1, 16'h0201);
      bus(8'h32, 1, 16'h0005);
      bus(8'h34, 1, 16'h0000);
      bus(8'h36, 1, 16'h0009);
      bus(8'h39, 1, 16'h0003);
      // macrotick parks on timer 1's offset a few cycles to tempt a repeat
      for (int c = 0; c < 8; c++) begin
         for (int m = 0; m < 10; m++) begin
            @(posedge sys_clk);
            {cycleCount, macrotick} <= {6'(c), 16'(m)};
         end
         repeat (3) @(posedge sys_clk);
      end
      repeat (2) @(posedge sys_clk);
      chk("ev0", 32'(ev0), 32'd2);
      chk("ev1", 32'(ev1), 32'd8);
      chk("irq", 32'(irq), 32'h1);
      bus(8'h38, 0, 16'h0);
      chk("stat", rd, 32'h3);
      bus(8'h38, 0, 16'h0);
      chk("clr", rd, 32'h0);
      chk("irq0", 32'(irq), 32'h0);
      finish_test();
   end
endmodule
bind gtt_timers gtt_timers_chk chk (.sys_clk(sys_clk), .rst(rst), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbSel(wbSel),
   .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .cycleCount(cycleCount), .macrotick(macrotick), .wbDatO(wbDatO),
   .wbAck(wbAck), .timerEvent(timerEvent), .irq(irq));
